// *** rtl/mrs_pwm_chan.sv ***
// Peak-current PWM latch for one switching channel
`timescale 1ns/100ps

module mrs_pwm_chan (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control from the sequencer and oscillator
  input wire logic run,
  input wire logic per_start,
  // Analog comparators
  input wire logic cs_trip,
  input wire logic sink_lim,
  // Switch drives
  output logic hs_on_ff,
  output logic ls_on_ff
);

  // Period start wins, so a sink trip lasts until the next period
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hs_on_ff <= 1'b0;
      ls_on_ff <= 1'b0;
    end else if (!run) begin
      hs_on_ff <= 1'b0;
      ls_on_ff <= 1'b0;
    end else if (per_start) begin
      hs_on_ff <= 1'b1;
      ls_on_ff <= 1'b0;
    end else if (ls_on_ff && sink_lim) begin
      hs_on_ff <= 1'b0;
      ls_on_ff <= 1'b0;
    end else if (hs_on_ff && cs_trip) begin
      hs_on_ff <= 1'b0;
      ls_on_ff <= 1'b1;
    end
  end

endmodule

// *** rtl/mrs_ramp.sv ***
// Soft-start reference ramp for one channel
`timescale 1ns/100ps
`include "mrs_consts.svh"

module mrs_ramp #(
  parameter int PRESC = 196
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Ramp runs while high, restarts from zero when dropped
  input wire logic run,
  // Reference code and completion
  output logic [7:0] ref_ff,
  output logic done_ff
);

  logic [15:0] pre_ff;

  // One reference step every PRESC clocks until full scale
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre_ff <= 16'h0000;
      ref_ff <= 8'h00;
      done_ff <= 1'b0;
    end else if (!run) begin
      pre_ff <= 16'h0000;
      ref_ff <= 8'h00;
      done_ff <= 1'b0;
    end else if (!done_ff) begin
      if (pre_ff == 16'(PRESC - 1)) begin
        pre_ff <= 16'h0000;
        ref_ff <= ref_ff + 8'h01;
        done_ff <= (ref_ff == 8'(`MRS_SS_STEPS - 1));
      end else begin
        pre_ff <= pre_ff + 16'h0001;
      end
    end
  end

endmodule

// *** rtl/mrs_supervisor_top.sv ***
// Rail supervisor: sequencing, PWM timing, reset output, register port
`timescale 1ns/100ps
`include "mrs_consts.svh"

//Function
// - High side at period start, low after trip
// - Common oscillator, channels quarter period apart
// - Valid external sync aligns channel one
// - Enable on rising, disable on falling crossing
// - Overvoltage lockout stops channels, reset low
// - Undervoltage monitor lowers reset, channels run
// - Undervoltage lockout stops channels, reset low
// - Power-good with undervoltage hysteresis
// - Output overvoltage stops switching, drops good
// - Only enabled channels checked for reset
// - Reset released after delay, conditions held
// - Reset falls after deglitched failure, or at once when all channels disabled
// - All channels disabled holds reset low
// - Reset pin open drain, active low
// - Soft-start ramp, longer for linear channel
// - Staggered enable delays after lockout exit
// - Simultaneous enables start in ascending order
// - Thermal recovery restarts soft start, sequence
// - Sink limit turns both switches off
// - Discharge switch on while channel disabled
module mrs_supervisor_top import mrs_pkg::*; #(
  parameter int SS_BUCK_CYC = `MRS_SS_BUCK_CYC,
  parameter int SS_LDO_CYC = `MRS_SS_LDO_CYC,
  parameter int POR_DLY_CYC = `MRS_POR_DLY_CYC,
  parameter int STEP_CYC = `MRS_STEP_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Input supply and thermal comparators
  input wire mrs_hyst_t [`MRS_NFLT-1:0] in_flt_cmp,
  // Per-channel comparators
  input wire mrs_ch_cmp_t [`MRS_NCH-1:0] ch_cmp,
  // External sync clock, sampled
  input wire logic sync_in,
  // Reset pin, open drain
  input wire logic por_in,
  output logic por_o,
  output logic por_oe,
  // Power stage drives
  output logic [`MRS_NSW-1:0] hs_on,
  output logic [`MRS_NSW-1:0] ls_on,
  output logic [`MRS_NCH-1:0] ch_on,
  output logic [`MRS_NCH-1:0] discharge_on,
  output logic [`MRS_NCH-1:0][7:0] ss_ref,
  output logic [`MRS_NCH-1:0] pg_out,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int PER = `MRS_OSC_PER_CYC;
  localparam int QTR = PER / 4;
  localparam int SMIN = `MRS_SYNC_MIN_CYC;
  localparam int SMAX = `MRS_SYNC_MAX_CYC;

  wire [`MRS_NFLT-1:0] flt_v;
  wire [`MRS_NCH-1:0] en_v;
  wire [`MRS_NCH-1:0] pg_v;
  wire [2*`MRS_NCH-1:0] seq_v;
  logic lock_any;
  logic cond_ok;
  logic ctrl_sync_ff;

  // Oscillator and sync state
  logic [5:0] ph_ff;
  logic [5:0] sper_ff;
  logic sync_d_ff;
  logic sync_lock_ff;
  logic [`MRS_NSW-1:0] pstart_ff;
  logic sync_rise;
  logic sync_ok;

  // Reset supervisor state
  logic [19:0] por_cnt_ff;

  // Bus state
  logic aw_got_ff;
  logic w_got_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic wr_go;
  logic [31:0] rd_data;
  logic rd_hit;
  logic wr_hit;

  // Input fault latches; the trip wins over a release in one cycle
  for (genvar f = 0; f < `MRS_NFLT; f++) begin : g_flt
    logic flt_ff;
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        flt_ff <= 1'b0;
      end else if (in_flt_cmp[f].set) begin
        flt_ff <= 1'b1;
      end else if (in_flt_cmp[f].clr) begin
        flt_ff <= 1'b0;
      end
    end
    assign flt_v[f] = flt_ff;
  end

  assign lock_any = flt_v[`MRS_FLT_INPUT_OVERVOLTAGE_LOCKOUT] | flt_v[`MRS_FLT_INPUT_UNDERVOLTAGE_LOCKOUT] |
                    flt_v[`MRS_FLT_TSD];

  // Sync edge and period check against the accepted window
  assign sync_rise = sync_in && !sync_d_ff;
  assign sync_ok = ctrl_sync_ff && sync_rise &&
                   (sper_ff >= 6'(SMIN - 1)) && (sper_ff <= 6'(SMAX - 1));

  // Sync period measurement and lock flag
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync_d_ff <= 1'b0;
      sper_ff <= 6'h3F;
      sync_lock_ff <= 1'b0;
    end else begin
      sync_d_ff <= sync_in;
      if (sync_rise) begin
        sper_ff <= 6'h00;
        sync_lock_ff <= sync_ok;
      end else if (sper_ff != 6'h3F) begin
        sper_ff <= sper_ff + 6'h01;
        if (sper_ff >= 6'(SMAX - 1)) begin
          sync_lock_ff <= 1'b0;
        end
      end
      if (!ctrl_sync_ff) begin
        sync_lock_ff <= 1'b0;
      end
    end
  end

  // Phase counter; fallback just keeps counting, so no phase jump
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ph_ff <= 6'h00;
    end else if (sync_ok) begin
      ph_ff <= 6'h00;
    end else if (ph_ff >= 6'(PER - 1)) begin
      ph_ff <= 6'h00;
    end else begin
      ph_ff <= ph_ff + 6'h01;
    end
  end

  // Period start pulses, one per switching channel
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pstart_ff <= '0;
    end else begin
      for (int k = 0; k < `MRS_NSW; k++) begin
        pstart_ff[k] <= (ph_ff == 6'(k * QTR));
      end
    end
  end

  // Per-channel latches, sequencer, ramp and switch control
  for (genvar i = 0; i < `MRS_NCH; i++) begin : g_ch
    localparam int DLY = (i == 0) ? `MRS_SEQ1_DLY_CYC : i * STEP_CYC;
    localparam int SSC = (i == `MRS_NCH - 1) ? SS_LDO_CYC : SS_BUCK_CYC;
    localparam int PRE = (SSC / `MRS_SS_STEPS > 0) ?
                         SSC / `MRS_SS_STEPS : 1;
    logic en_ff;
    logic uv_ff;
    logic ov_ff;
    logic pg_ff;
    logic on_ff;
    logic dis_ff;
    logic ramp_done;
    logic run;
    mrs_seq_t seq_ff;
    logic [19:0] dly_ff;

    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        en_ff <= 1'b0;
      end else if (ch_cmp[i].en.set) begin
        en_ff <= 1'b1;
      end else if (ch_cmp[i].en.clr) begin
        en_ff <= 1'b0;
      end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        uv_ff <= 1'b1;
      end else if (ch_cmp[i].uv.set) begin
        uv_ff <= 1'b1;
      end else if (ch_cmp[i].uv.clr) begin
        uv_ff <= 1'b0;
      end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        ov_ff <= 1'b0;
      end else if (ch_cmp[i].ov.set) begin
        ov_ff <= 1'b1;
      end else if (ch_cmp[i].ov.clr) begin
        ov_ff <= 1'b0;
      end
    end

    // Start-up sequence; any lockout sends the channel back to off
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        seq_ff <= SEQ_OFF;
        dly_ff <= 20'h0_0000;
      end else if (!en_ff || lock_any) begin
        seq_ff <= SEQ_OFF;
        dly_ff <= 20'h0_0000;
      end else begin
        case (seq_ff)
          SEQ_OFF: begin
            seq_ff <= SEQ_DELAY;
          end
          SEQ_DELAY: begin
            if (dly_ff >= 20'(DLY - 1)) begin
              seq_ff <= SEQ_SOFT;
            end else begin
              dly_ff <= dly_ff + 20'h0_0001;
            end
          end
          SEQ_SOFT: begin
            if (ramp_done) begin
              seq_ff <= SEQ_RUN;
            end
          end
          SEQ_RUN: begin
            seq_ff <= SEQ_RUN;
          end
          default: begin
            seq_ff <= SEQ_OFF;
          end
        endcase
      end
    end

    assign run = ((seq_ff == SEQ_SOFT) || (seq_ff == SEQ_RUN)) && !ov_ff;

    // Registered stage enable, power-good and discharge
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        on_ff <= 1'b0;
        pg_ff <= 1'b0;
        dis_ff <= 1'b1;
      end else begin
        on_ff <= run;
        pg_ff <= !uv_ff && !ov_ff;
        dis_ff <= !en_ff;
      end
    end

    mrs_ramp #(
      .PRESC(PRE)
    ) u_ramp (
      .sys_clk(sys_clk),
      .rst(rst),
      .run((seq_ff == SEQ_SOFT) || (seq_ff == SEQ_RUN)),
      .ref_ff(ss_ref[i]),
      .done_ff(ramp_done)
    );

    // Only switching channels have a PWM latch
    if (i < `MRS_NSW) begin : g_sw
      mrs_pwm_chan u_pwm (
        .sys_clk(sys_clk),
        .rst(rst),
        .run(run),
        .per_start(pstart_ff[i]),
        .cs_trip(ch_cmp[i].cs_trip),
        .sink_lim(ch_cmp[i].sink_lim),
        .hs_on_ff(hs_on[i]),
        .ls_on_ff(ls_on[i])
      );
    end

    assign en_v[i] = en_ff;
    assign pg_v[i] = pg_ff;
    assign ch_on[i] = on_ff;
    assign discharge_on[i] = dis_ff;
    assign pg_out[i] = pg_ff;
    assign seq_v[2*i +: 2] = seq_ff;
  end

  assign cond_ok = !(|flt_v) && (&(pg_v | ~en_v));

  // Reset output: por_oe high pulls the pin low, open drain
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      por_oe <= 1'b1;
      por_cnt_ff <= 20'h0_0000;
    end else if (!(|en_v)) begin
      por_oe <= 1'b1;
      por_cnt_ff <= 20'h0_0000;
    end else if (por_oe) begin
      if (!cond_ok) begin
        por_cnt_ff <= 20'h0_0000;
      end else if (por_cnt_ff >= 20'(POR_DLY_CYC - 1)) begin
        por_oe <= 1'b0;
        por_cnt_ff <= 20'h0_0000;
      end else begin
        por_cnt_ff <= por_cnt_ff + 20'h0_0001;
      end
    end else begin
      if (cond_ok) begin
        por_cnt_ff <= 20'h0_0000;
      end else if (por_cnt_ff >= 20'(`MRS_DEGLITCH_CYC - 1)) begin
        por_oe <= 1'b1;
        por_cnt_ff <= 20'h0_0000;
      end else begin
        por_cnt_ff <= por_cnt_ff + 20'h0_0001;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      por_o <= 1'b0;
    end else begin
      por_o <= 1'b0;
    end
  end

  // Bus write accepted once address and data are both held
  assign wr_go = aw_got_ff && w_got_ff && !s_axi_bvalid;
  assign wr_hit = (awaddr_ff[7:2] == `MRS_CTRL_OFS >> 2) ||
                  (awaddr_ff[7:2] == `MRS_STAT_OFS >> 2) ||
                  (awaddr_ff[7:2] == `MRS_SEQ_OFS >> 2);

  // Write address channel; ready returns after the response
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      aw_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_got_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_got_ff <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel, same pattern as the address
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_wready <= 1'b1;
      w_got_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_got_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (wr_go) begin
      w_got_ff <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response; unmapped addresses answer with an error
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MRS_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `MRS_RESP_OKAY : `MRS_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register: sync follow enable, byte lane zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_sync_ff <= `MRS_CTRL_RST;
    end else if (wr_go && wstrb_ff[0] &&
                 (awaddr_ff[7:2] == `MRS_CTRL_OFS >> 2)) begin
      ctrl_sync_ff <= wdata_ff[`MRS_CTRL_SYNC_BIT];
    end
  end

  // Read mux; status and sequence words are read-only
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr[7:2])
      `MRS_CTRL_OFS >> 2: begin
        rd_data[`MRS_CTRL_SYNC_BIT] = ctrl_sync_ff;
      end
      `MRS_STAT_OFS >> 2: begin
        rd_data[`MRS_STAT_EN_LSB +: `MRS_NCH] = en_v;
        rd_data[`MRS_STAT_PG_LSB +: `MRS_NCH] = pg_v;
        rd_data[`MRS_STAT_FLT_LSB +: `MRS_NFLT] = flt_v;
        rd_data[`MRS_STAT_POR_BIT] = !por_oe;
        rd_data[`MRS_STAT_LOCK_BIT] = sync_lock_ff;
        rd_data[`MRS_STAT_PIN_BIT] = por_in;
      end
      `MRS_SEQ_OFS >> 2: begin
        rd_data[2*`MRS_NCH-1:0] = seq_v;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read channel; data register one edge after the address
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `MRS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_hit ? `MRS_RESP_OKAY : `MRS_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// *** shared/mrs_consts.svh ***
// Constants of the rail supervisor: counts, timing and register map
`ifndef MRS_CONSTS_SVH
`define MRS_CONSTS_SVH

// Channel counts: four switching channels, then the linear one
`define MRS_NCH 5
`define MRS_NSW 4
`define MRS_NFLT 4

// Index of each input fault latch
`define MRS_FLT_INPUT_OVERVOLTAGE_LOCKOUT 0
`define MRS_FLT_UVM 1
`define MRS_FLT_INPUT_UNDERVOLTAGE_LOCKOUT 2
`define MRS_FLT_TSD 3

// Clock and oscillator rates in MHz
`define MRS_CLK_MHZ 100.0
`define MRS_OSC_MHZ 3.2
`define MRS_SYNC_MIN_MHZ 2.8
`define MRS_SYNC_MAX_MHZ 3.5

// Oscillator period and accepted sync period window, in clocks
`define MRS_OSC_PER_CYC $rtoi(`MRS_CLK_MHZ / `MRS_OSC_MHZ)
`define MRS_SYNC_MIN_CYC $rtoi(`MRS_CLK_MHZ / `MRS_SYNC_MAX_MHZ)
`define MRS_SYNC_MAX_CYC ($rtoi(`MRS_CLK_MHZ / `MRS_SYNC_MIN_MHZ) + 1)

// Times in their own units
`define MRS_SEQ1_DLY_US 15.0
`define MRS_SS_BUCK_US 500.0
`define MRS_SS_LDO_US 570.0
`define MRS_POR_DLY_MS 5.7
`define MRS_DEGLITCH_US 10.0

// Least times rounded up to whole clocks
`define MRS_SEQ1_DLY_CYC $rtoi(`MRS_SEQ1_DLY_US * `MRS_CLK_MHZ + 0.999)
`define MRS_SS_BUCK_CYC $rtoi(`MRS_SS_BUCK_US * `MRS_CLK_MHZ + 0.999)
`define MRS_SS_LDO_CYC $rtoi(`MRS_SS_LDO_US * `MRS_CLK_MHZ + 0.999)
`define MRS_POR_DLY_CYC \
  $rtoi(`MRS_POR_DLY_MS * 1000.0 * `MRS_CLK_MHZ + 0.999)
`define MRS_DEGLITCH_CYC $rtoi(`MRS_DEGLITCH_US * `MRS_CLK_MHZ + 0.999)

// Stagger step default and soft-start reference steps
`define MRS_STEP_CYC 2000
`define MRS_SS_STEPS 255

// Register map, byte addresses
`define MRS_CTRL_OFS 8'h00
`define MRS_STAT_OFS 8'h04
`define MRS_SEQ_OFS 8'h08
`define MRS_CTRL_RST 1'b1
`define MRS_CTRL_SYNC_BIT 0

// Status register fields
`define MRS_STAT_EN_LSB 0
`define MRS_STAT_PG_LSB 8
`define MRS_STAT_FLT_LSB 16
`define MRS_STAT_POR_BIT 20
`define MRS_STAT_LOCK_BIT 21
`define MRS_STAT_PIN_BIT 22

// Bus responses
`define MRS_RESP_OKAY 2'b00
`define MRS_RESP_SLVERR 2'b10

`endif

// *** shared/mrs_pkg.sv ***
// Types shared by the rail supervisor modules
package mrs_pkg;

  // One comparator pair with hysteresis: set trips, clr releases
  typedef struct packed {
    logic set;
    logic clr;
  } mrs_hyst_t;

  // Per-channel comparator bundle
  typedef struct packed {
    mrs_hyst_t en;
    mrs_hyst_t uv;
    mrs_hyst_t ov;
    logic cs_trip;
    logic sink_lim;
  } mrs_ch_cmp_t;

  // Channel start-up sequence, Gray coded along the path
  typedef enum logic [1:0] {
    SEQ_OFF = 2'b00,
    SEQ_DELAY = 2'b01,
    SEQ_SOFT = 2'b11,
    SEQ_RUN = 2'b10
  } mrs_seq_t;

endpackage

// *** test/mrs_rail_model.sv ***
// Behavioural comparators, reset pull-up and sync source
`timescale 1ns/100ps

module mrs_rail_model import mrs_pkg::*; (
  // Clock
  input wire logic sys_clk,
  // Levels commanded by the bench
  input wire logic [4:0] en_req,
  input wire logic [3:0] flt_req,
  input wire logic [4:0] uv_req,
  input wire logic [4:0] ov_req,
  input wire logic sync_en,
  // Supervisor outputs sensed
  input wire logic [3:0] hs_on,
  input wire logic [4:0] ch_on,
  input wire logic por_oe,
  // Comparator and pin levels
  output mrs_hyst_t [3:0] in_flt_cmp,
  output mrs_ch_cmp_t [4:0] ch_cmp,
  output logic sync_in,
  output logic por_in
);
  logic [4:0][3:0] ramp_ff = '0;
  logic [4:0] sync_cnt_ff = 5'h00;
  // Inductor current grows while the high side conducts
  always_ff @(posedge sys_clk)
    for (int k = 0; k < 4; k++)
      ramp_ff[k] <= hs_on[k] ? ramp_ff[k] + 4'h1 : 4'h0;
  // Output stays low until its channel runs, whatever is commanded
  always_comb begin
    for (int k = 0; k < 4; k++)
      in_flt_cmp[k] = {flt_req[k], ~flt_req[k]};
    for (int k = 0; k < 5; k++)
      ch_cmp[k] = {en_req[k], ~en_req[k], ~ch_on[k] | uv_req[k],
        ch_on[k] & ~uv_req[k], ov_req[k], ~ov_req[k],
        ramp_ff[k] >= 4'h8, 1'b0};
  end
  // sync: 32-cycle period, held low when unused
  always_ff @(posedge sys_clk)
    sync_cnt_ff <= sync_cnt_ff + 5'h01;
  assign sync_in = sync_en & sync_cnt_ff[4];
  // pull-up lifts the pin when released
  assign por_in = ~por_oe;
endmodule

// *** test/mrs_sup_sva.sv ***
// Pin-level assertions for the rail supervisor
`timescale 1ns/100ps
`include "mrs_consts.svh"

module mrs_sup_sva import mrs_pkg::*; #(
  parameter int POR_DLY_CYC = 200
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Comparators
  input wire mrs_hyst_t [`MRS_NFLT-1:0] in_flt_cmp,
  input wire mrs_ch_cmp_t [`MRS_NCH-1:0] ch_cmp,
  // Outputs watched
  input wire logic por_o,
  input wire logic por_oe,
  input wire logic [`MRS_NSW-1:0] hs_on,
  input wire logic [`MRS_NSW-1:0] ls_on,
  input wire logic [`MRS_NCH-1:0] discharge_on,
  input wire logic [`MRS_NCH-1:0] pg_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic all_off;
  logic [31:0] ok_cnt_ff;
  // Every enable below its falling level
  always_comb begin
    all_off = 1'b1;
    for (int k = 0; k < 5; k++)
      all_off &= ch_cmp[k].en.clr & ~ch_cmp[k].en.set;
  end
  // Clean input run length; set bits are the odd ones
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      ok_cnt_ff <= 32'h0000_0000;
    else
      ok_cnt_ff <= |(in_flt_cmp & 8'hAA) ? 32'h0000_0000 : ok_cnt_ff + 1;
  end
  property p_od; por_o == 1'b0; endproperty
  a_od: assert property (p_od)
    else $error("reset pin data not low");
  property p_dis; ch_cmp[0].en.clr && !ch_cmp[0].en.set |-> ##[1:2]
    discharge_on[0]; endproperty
  a_dis: assert property (p_dis)
    else $error("discharge off while disabled");
  property p_off; all_off [*4] |-> por_oe; endproperty
  a_off: assert property (p_off)
    else $error("reset released with all channels off");
  property p_hsls; (hs_on & ls_on) == 4'h0; endproperty
  a_hsls: assert property (p_hsls)
    else $error("both switches on");
  property p_trip; hs_on[0] && ch_cmp[0].cs_trip |-> ##[1:2] !hs_on[0];
  endproperty
  a_trip: assert property (p_trip)
    else $error("high side kept on after trip");
  property p_ov; ch_cmp[1].ov.set [*3] |-> !hs_on[1] && !ls_on[1] &&
    !pg_out[1]; endproperty
  a_ov: assert property (p_ov)
    else $error("switching during overvoltage");
  property p_uv; ch_cmp[2].uv.set [*3] |-> !pg_out[2]; endproperty
  a_uv: assert property (p_uv)
    else $error("good during undervoltage");
  property p_pgup; $rose(pg_out[2]) |-> $past(ch_cmp[2].uv.clr, 2);
  endproperty
  a_pgup: assert property (p_pgup)
    else $error("good rose below rising level");
  property p_rel; $fell(por_oe) |-> ok_cnt_ff >= POR_DLY_CYC; endproperty
  a_rel: assert property (p_rel)
    else $error("reset released too early");
endmodule

bind mrs_supervisor_top mrs_sup_sva #(.POR_DLY_CYC(POR_DLY_CYC))
  mrs_sup_sva_i (.sys_clk, .rst, .in_flt_cmp, .ch_cmp, .por_o, .por_oe,
  .hs_on, .ls_on, .discharge_on, .pg_out);

// *** test/testbench.sv ***
// Self-checking bench for the rail supervisor
`timescale 1ns/100ps
`include "mrs_consts.svh"

module testbench import mrs_pkg::*;;
  logic sys_clk = 1'b0, rst = 1'b1, sync_en = 1'b0;
  logic [4:0] en_req = '0, uv_req = '0, ov_req = '0;
  logic [3:0] flt_req = '0, s_axi_wstrb = 4'hf, hs_on, ls_on;
  mrs_hyst_t [3:0] in_flt_cmp;
  mrs_ch_cmp_t [4:0] ch_cmp;
  logic sync_in, por_in, por_o, por_oe;
  logic [4:0] ch_on, discharge_on, pg_out;
  logic [4:0][7:0] ss_ref;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int errors = 0, checks = 0;

  mrs_supervisor_top #(.SS_BUCK_CYC(510), .SS_LDO_CYC(765),
    .POR_DLY_CYC(200)) mrs_supervisor_top_i (.sys_clk, .rst, .in_flt_cmp,
    .ch_cmp, .sync_in, .por_in, .por_o, .por_oe, .hs_on, .ls_on, .ch_on,
    .discharge_on, .ss_ref, .pg_out, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  mrs_rail_model mrs_rail_model_i (.sys_clk, .en_req, .flt_req, .uv_req,
    .ov_req, .sync_en, .hs_on, .ch_on, .por_oe, .in_flt_cmp, .ch_cmp,
    .sync_in, .por_in);

  // Free-running 100 MHz clock
  initial forever #5 sys_clk = ~sys_clk;

  task automatic conclude();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask

  // A used-up wait ends the run at once
  task automatic tmo(input int i, input int n);
    if (i >= n) begin
      chk(1'b0, "timeout");
      conclude();
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
    tmo(i, 50);
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    tmo(i, 50);
  endtask

  // Wait for all rails running, then for the reset pin to let go
  task automatic up(output int i);
    int j;
    for (i = 0; i < 9000 && ch_on !== 5'h1f; i++)
      @(posedge sys_clk);
    tmo(i, 9000);
    for (j = 0; j < 1000 && por_oe !== 1'b0; j++)
      @(posedge sys_clk);
    tmo(j, 1000);
  endtask

  task automatic t_start();
    int t [5];
    int i;
    t = '{default: -1};
    chk(por_oe === 1'b1 && discharge_on === 5'h1f, "reset state");
    en_req <= 5'h1f;
    for (i = 0; i < 9000 && ss_ref[4] !== 8'hff; i++) begin
      @(posedge sys_clk);
      for (int k = 0; k < 5; k++)
        if (ch_on[k] === 1'b1 && t[k] < 0) t[k] = i;
    end
    tmo(i, 9000);
    chk(t[0] < t[1] && t[1] < t[2] && t[2] < t[3] && t[3] < t[4], "order");
    chk(t[0] >= 1500 && t[0] <= 1510, "first start");
    chk(t[4] >= 8000 && t[4] <= 8010, "last start");
    chk(i - t[4] >= 760 && i - t[4] <= 770, "ramp time");
    chk(ss_ref[4] === 8'hff && discharge_on === 5'h00, "ramp end");
    up(i);
    chk(por_in === 1'b1, "pin not high");
  endtask

  task automatic t_uvm();
    int i;
    flt_req[1] <= 1'b1;
    cyc(5);
    flt_req[1] <= 1'b0;
    cyc(20);
    chk(por_oe === 1'b0, "short fault dropped reset");
    flt_req[1] <= 1'b1;
    cyc(990);
    chk(por_oe === 1'b0, "reset dropped early");
    cyc(20);
    chk(por_oe === 1'b1 && ch_on === 5'h1f, "monitor fault");
    flt_req[1] <= 1'b0;
    up(i);
  endtask

  task automatic t_out();
    ov_req[1] <= 1'b1;
    uv_req[2] <= 1'b1;
    cyc(4);
    chk(hs_on[1] === 1'b0 && pg_out[1] === 1'b0, "ov switching");
    chk(pg_out[2] === 1'b0 && ch_on[2] === 1'b1, "uv good");
    ov_req[1] <= 1'b0;
    uv_req[2] <= 1'b0;
    cyc(8);
    chk(pg_out[2:1] === 2'h3 && por_oe === 1'b0, "recovery");
  endtask

  task automatic t_bus();
    logic [31:0] d;
    logic [1:0] r;
    sync_en <= 1'b1;
    cyc(200);
    axr(`MRS_STAT_OFS, d, r);
    chk(d[`MRS_STAT_LOCK_BIT] === 1'b1 && r === 2'b00, "no lock");
    sync_en <= 1'b0;
    cyc(60);
    axr(`MRS_STAT_OFS, d, r);
    chk(d[`MRS_STAT_LOCK_BIT] === 1'b0 && ch_on === 5'h1f, "lost");
    axw(`MRS_CTRL_OFS, 32'h0000_0000, r);
    axr(`MRS_CTRL_OFS, d, r);
    chk(d[0] === 1'b0 && r === 2'b00, "control readback");
    axr(8'h0c, d, r);
    chk(r === 2'b10 && d === 32'h0000_0000, "unmapped read");
    axw(`MRS_CTRL_OFS, 32'h0000_0001, r);
  endtask

  // Overvoltage, undervoltage lockout, thermal: each restarts the sequence
  task automatic t_lock();
    int f [3] = '{0, 2, 3};
    int i;
    foreach (f[n]) begin
      flt_req[f[n]] <= 1'b1;
      cyc(1010);
      chk(ch_on === 5'h00 && por_oe === 1'b1, "lockout");
      flt_req[f[n]] <= 1'b0;
      up(i);
      chk(i > 8000, "no staggered restart");
    end
  endtask

  task automatic t_off();
    en_req <= 5'h0f;
    cyc(1100);
    chk(por_oe === 1'b0 && discharge_on === 5'h10, "unwatched");
    en_req <= 5'h00;
    cyc(4);
    chk(por_oe === 1'b1 && ch_on === 5'h00, "all off");
  endtask

  initial begin
    cyc(6);
    rst <= 1'b0;
    cyc(1);
    t_start();
    t_uvm();
    t_out();
    t_bus();
    t_lock();
    t_off();
    conclude();
  end
endmodule
